// ---- rtl/tft_twin_timer.sv ----
`timescale 1ns/100ps

// Summary of operation
// - Off period set from zero counts; range up to 9999 hours.
// - On period at least one count; zero is raised to one.
// - Presented value is elapsed time in up mode, remaining in down mode.
// - Output mode selects off-first or on-first sequence.
// - Start and reset are filtered with a shared 20 ms or 1 ms width.
// - Presented set value follows the period being timed.
// - Start begins timing; start changes are ignored while timing.
// - Off-first: output starts low and toggles at every period end.
// - On-first: output starts high and toggles at every period end.
// - Start already active at power-up or reset release begins timing.
// - Retaining variant keeps value and output across power loss.
// - Instantaneous models start without waiting for start input.
// - Selection mode clears value, drops output and suspends timing.
// - Configuration applies on return to run; a change forces a reset. Set values apply at once.
module tft_twin_timer #(
  parameter int MS_CYCLES = tft_pkg::MS_CYCLES
) (
  // Clock and reset.
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave.
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Panel pins.
  input  wire logic        start_in,
  input  wire logic        reset_in,
  input  wire logic        power_ok_in,
  output logic             ctrl_out
);

  // ----------------------------------------------------------------------
  // Helper functions.
  // ----------------------------------------------------------------------
  // Milliseconds per count for a time range code.
  function automatic logic [tft_pkg::UL_W-1:0] unit_len(input logic [2:0] u);
    unique case (u)
      tft_pkg::U_10MS:  unit_len = tft_pkg::UL_10MS;
      tft_pkg::U_100MS: unit_len = tft_pkg::UL_100MS;
      tft_pkg::U_1S:    unit_len = tft_pkg::UL_1S;
      tft_pkg::U_1MIN:  unit_len = tft_pkg::UL_1MIN;
      tft_pkg::U_1H:    unit_len = tft_pkg::UL_1H;
      default:          unit_len = tft_pkg::UL_1MS;
    endcase
  endfunction

  // Limits a written set value to four decimal digits.
  function automatic logic [tft_pkg::SV_W-1:0] clamp_sv(input logic [31:0] d);
    if (d[tft_pkg::SV_W-1:0] > tft_pkg::SV_MAX || d[31:tft_pkg::SV_W] != '0) begin
      clamp_sv = tft_pkg::SV_MAX;
    end else begin
      clamp_sv = d[tft_pkg::SV_W-1:0];
    end
  endfunction

  // ----------------------------------------------------------------------
  // Declarations.
  // ----------------------------------------------------------------------
  logic [2:0]                  sync1_ff, sync2_ff;
  logic [tft_pkg::MS_CNT_W-1:0] ms_cnt_ff, nxt_ms_cnt;
  logic                        ms_tick;
  logic [1:0][4:0]             db_cnt_ff, nxt_db_cnt;
  logic [1:0]                  db_ff, nxt_db;
  logic [4:0]                  db_width;
  logic                        start_db, reset_db, pwr;
  logic                        ap_wr_ff, nxt_ap_wr;
  logic [tft_pkg::AW-1:0]      ap_addr_ff, nxt_ap_addr;
  logic [31:0]                 hrdata_ff, nxt_hrdata;
  logic                        sel_ff, nxt_sel, auto_rst_ff, nxt_auto_rst;
  tft_pkg::tft_cfg_s           cfg_sh_ff, nxt_cfg_sh, cfg_act_ff, nxt_cfg_act;
  logic [tft_pkg::SV_W-1:0]    set_off_ff, nxt_set_off, set_on_ff, nxt_set_on;
  tft_pkg::tft_state_e         state_ff, nxt_state;
  logic                        phase_ff, nxt_phase, out_ff, nxt_out;
  logic [tft_pkg::SV_W-1:0]    val_ff, nxt_val;
  logic [tft_pkg::UL_W-1:0]    unit_cnt_ff, nxt_unit_cnt;
  logic [tft_pkg::SV_W-1:0]    on_eff, cur_set, pv;
  logic [2:0]                  cur_unit;
  logic                        clear, hold, expire, sel_exit;

  // ----------------------------------------------------------------------
  // Pin synchronisers, time base and input filters.
  // ----------------------------------------------------------------------
  // Two-stage synchronisers for start, reset and power.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_ff <= 3'h0;
      sync2_ff <= 3'h0;
    end else begin
      sync1_ff <= {power_ok_in, reset_in, start_in};
      sync2_ff <= sync1_ff;
    end
  end

  assign pwr      = sync2_ff[2];
  assign ms_tick  = (ms_cnt_ff == tft_pkg::MS_CNT_W'(MS_CYCLES - 1));
  assign db_width = cfg_act_ff.short_width ? tft_pkg::DB_SHORT_MS : tft_pkg::DB_LONG_MS;
  assign start_db = db_ff[0];
  assign reset_db = db_ff[1];

  // Millisecond prescaler and pulse-width filters.
  always_comb begin
    nxt_ms_cnt = ms_tick ? '0 : ms_cnt_ff + 1'b1;
    nxt_db     = db_ff;
    nxt_db_cnt = db_cnt_ff;
    for (int i = 0; i < 2; i++) begin
      if (sync2_ff[i] == db_ff[i]) begin
        nxt_db_cnt[i] = '0;
      end else if (ms_tick) begin
        if (db_cnt_ff[i] >= db_width) begin
          nxt_db[i]     = sync2_ff[i];
          nxt_db_cnt[i] = '0;
        end else begin
          nxt_db_cnt[i] = db_cnt_ff[i] + 1'b1;
        end
      end
    end
  end

  // Time base and filter registers.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ms_cnt_ff <= '0;
      db_ff     <= 2'h0;
      db_cnt_ff <= '0;
    end else begin
      ms_cnt_ff <= nxt_ms_cnt;
      db_ff     <= nxt_db;
      db_cnt_ff <= nxt_db_cnt;
    end
  end

  // ----------------------------------------------------------------------
  // Bus slave and registers.
  // ----------------------------------------------------------------------
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_ff;
  assign sel_exit  = ap_wr_ff && ap_addr_ff == tft_pkg::ADDR_CTRL && sel_ff
                     && !hwdata[tft_pkg::CTRL_SEL_BIT];

  // Address phase capture, read data and register writes.
  always_comb begin
    nxt_ap_wr    = hsel && hready && htrans[1] && hwrite;
    nxt_ap_addr  = haddr[tft_pkg::AW-1:0];
    nxt_hrdata   = hrdata_ff;
    nxt_sel      = sel_ff;
    nxt_cfg_sh   = cfg_sh_ff;
    nxt_cfg_act  = cfg_act_ff;
    nxt_set_off  = set_off_ff;
    nxt_set_on   = set_on_ff;
    nxt_auto_rst = 1'b0;
    if (hsel && hready && htrans[1] && !hwrite) begin
      unique case (haddr[tft_pkg::AW-1:0])
        tft_pkg::ADDR_CTRL:    nxt_hrdata = 32'({cfg_sh_ff, sel_ff});
        tft_pkg::ADDR_SET_OFF: nxt_hrdata = 32'(set_off_ff);
        tft_pkg::ADDR_SET_ON:  nxt_hrdata = 32'(set_on_ff);
        tft_pkg::ADDR_STATUS:  nxt_hrdata = 32'({state_ff == tft_pkg::TM_RUN,
                                                 phase_ff, out_ff, pwr});
        tft_pkg::ADDR_PV:      nxt_hrdata = 32'(pv);
        tft_pkg::ADDR_DISP:    nxt_hrdata = 32'(cur_set);
        default:               nxt_hrdata = 32'h00000000;
      endcase
    end
    if (ap_wr_ff) begin
      unique case (ap_addr_ff)
        tft_pkg::ADDR_CTRL: begin
          nxt_sel    = hwdata[tft_pkg::CTRL_SEL_BIT];
          nxt_cfg_sh = hwdata[tft_pkg::CTRL_CFG_MSB:tft_pkg::CTRL_CFG_LSB];
        end
        tft_pkg::ADDR_SET_OFF: nxt_set_off = clamp_sv(hwdata);
        tft_pkg::ADDR_SET_ON:  nxt_set_on  = clamp_sv(hwdata);
        default: ;
      endcase
    end
    // Staged settings go live only when selection mode is left.
    if (sel_exit) begin
      nxt_cfg_act  = hwdata[tft_pkg::CTRL_CFG_MSB:tft_pkg::CTRL_CFG_LSB];
      nxt_auto_rst = (nxt_cfg_act != cfg_act_ff);
    end
  end

  // Bus and register flops.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_wr_ff    <= 1'b0;
      ap_addr_ff  <= '0;
      hrdata_ff   <= 32'h00000000;
      sel_ff      <= 1'b0;
      cfg_sh_ff   <= tft_pkg::CFG_RST;
      cfg_act_ff  <= tft_pkg::CFG_RST;
      set_off_ff  <= tft_pkg::SV_RST;
      set_on_ff   <= tft_pkg::SV_RST;
      auto_rst_ff <= 1'b0;
    end else begin
      ap_wr_ff    <= nxt_ap_wr;
      ap_addr_ff  <= nxt_ap_addr;
      hrdata_ff   <= nxt_hrdata;
      sel_ff      <= nxt_sel;
      cfg_sh_ff   <= nxt_cfg_sh;
      cfg_act_ff  <= nxt_cfg_act;
      set_off_ff  <= nxt_set_off;
      set_on_ff   <= nxt_set_on;
      auto_rst_ff <= nxt_auto_rst;
    end
  end

  // ----------------------------------------------------------------------
  // Twin period timer.
  // ----------------------------------------------------------------------
  // Period selection and presented value.
  always_comb begin
    on_eff   = (set_on_ff == tft_pkg::SV_RST) ? tft_pkg::SV_ONE : set_on_ff;
    cur_set  = phase_ff ? on_eff : set_off_ff;
    cur_unit = phase_ff ? cfg_act_ff.on_unit : cfg_act_ff.off_unit;
    pv       = cfg_act_ff.count_down ? cur_set - val_ff : val_ff;
    clear    = reset_db || sel_ff || auto_rst_ff
               || (!pwr && !cfg_act_ff.retain);
    hold     = !pwr && cfg_act_ff.retain;
    expire   = val_ff >= cur_set;
  end

  // Next state of the timer.
  always_comb begin
    nxt_state    = state_ff;
    nxt_phase    = phase_ff;
    nxt_out      = out_ff;
    nxt_val      = val_ff;
    nxt_unit_cnt = unit_cnt_ff;
    if (clear) begin
      nxt_state    = tft_pkg::TM_IDLE;
      nxt_phase    = 1'b0;
      nxt_out      = 1'b0;
      nxt_val      = '0;
      nxt_unit_cnt = '0;
    end else if (!hold) begin
      unique case (state_ff)
        tft_pkg::TM_IDLE: begin
          if (start_db || cfg_act_ff.instant) begin
            nxt_state    = tft_pkg::TM_RUN;
            nxt_phase    = cfg_act_ff.on_first;
            nxt_out      = cfg_act_ff.on_first;
            nxt_val      = '0;
            nxt_unit_cnt = '0;
          end
        end
        tft_pkg::TM_RUN: begin
          if (expire) begin
            nxt_phase    = !phase_ff;
            nxt_out      = !out_ff;
            nxt_val      = '0;
            nxt_unit_cnt = '0;
          end else if (ms_tick) begin
            if (unit_cnt_ff + 1'b1 >= unit_len(cur_unit)) begin
              nxt_unit_cnt = '0;
              nxt_val      = val_ff + 1'b1;
            end else begin
              nxt_unit_cnt = unit_cnt_ff + 1'b1;
            end
          end
        end
      endcase
    end
  end

  // Timer registers.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff    <= tft_pkg::TM_IDLE;
      phase_ff    <= 1'b0;
      out_ff      <= 1'b0;
      val_ff      <= '0;
      unit_cnt_ff <= '0;
    end else begin
      state_ff    <= nxt_state;
      phase_ff    <= nxt_phase;
      out_ff      <= nxt_out;
      val_ff      <= nxt_val;
      unit_cnt_ff <= nxt_unit_cnt;
    end
  end

  assign ctrl_out = out_ff;

  // ----------------------------------------------------------------------
  // Assertions.
  // ----------------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence seq_begin;
    state_ff == tft_pkg::TM_IDLE && !clear && !hold && (start_db || cfg_act_ff.instant);
  endsequence
  sequence seq_exit_changed;
    sel_exit && hwdata[tft_pkg::CTRL_CFG_MSB:tft_pkg::CTRL_CFG_LSB] != cfg_act_ff;
  endsequence
  AST_BEGIN_PHASE: assert property (seq_begin |=> state_ff == tft_pkg::TM_RUN
    && out_ff == $past(cfg_act_ff.on_first) && val_ff == '0)
    else $error("Timing did not begin in the selected phase.");
  AST_OUT_TRACKS_PHASE: assert property (state_ff == tft_pkg::TM_RUN
    |-> out_ff == phase_ff)
    else $error("Output does not follow the timed period.");
  AST_TOGGLE: assert property (state_ff == tft_pkg::TM_RUN && expire && !clear && !hold
    |=> out_ff != $past(out_ff) && val_ff == '0)
    else $error("Output did not toggle at period end.");
  AST_START_IGNORED: assert property (state_ff == tft_pkg::TM_RUN && !clear
    |=> state_ff == tft_pkg::TM_RUN)
    else $error("Timing stopped without a reset.");
  AST_CLEAR: assert property ((sel_ff || reset_db) |=> state_ff == tft_pkg::TM_IDLE
    && !out_ff && val_ff == '0)
    else $error("Selection or reset did not clear the timer.");
  AST_AUTO_RESET: assert property (seq_exit_changed |=> auto_rst_ff ##1
    (state_ff == tft_pkg::TM_IDLE && !out_ff))
    else $error("Changed settings did not force a reset.");
  AST_CFG_STABLE: assert property (!sel_exit |=> $stable(cfg_act_ff))
    else $error("Run settings changed outside selection exit.");
  AST_HOLD: assert property (hold && !clear |=> $stable(val_ff) && $stable(out_ff))
    else $error("Retained state moved while power was off.");
  AST_DOWN_VALUE: assert property (cfg_act_ff.count_down && !expire
    |-> pv != '0 && pv <= cur_set)
    else $error("Down count is not the remaining time.");
  AST_ON_MIN: assert property (phase_ff |-> cur_set != '0)
    else $error("On period shorter than one count.");
  AST_FILTER: assert property ($changed(db_ff) |-> $past(ms_tick))
    else $error("Filtered input changed off the millisecond tick.");

endmodule // tft_twin_timer

// ---- common/tft_pkg.sv ----
package tft_pkg;

  // ----------------------------------------------------------------------
  // Timing.
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int MS_TIME_NS    = 1000000;
  localparam int MS_CYCLES     = (MS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MS_CNT_W      = 15;
  localparam logic [4:0] DB_LONG_MS  = 5'h14;  // 20 ms input width.
  localparam logic [4:0] DB_SHORT_MS = 5'h01;  // 1 ms input width.

  // ----------------------------------------------------------------------
  // Register map (byte addresses) and fields.
  // ----------------------------------------------------------------------
  localparam int AW = 8;
  localparam logic [AW-1:0] ADDR_CTRL    = 8'h00;
  localparam logic [AW-1:0] ADDR_SET_OFF = 8'h04;
  localparam logic [AW-1:0] ADDR_SET_ON  = 8'h08;
  localparam logic [AW-1:0] ADDR_STATUS  = 8'h0C;
  localparam logic [AW-1:0] ADDR_PV      = 8'h10;
  localparam logic [AW-1:0] ADDR_DISP    = 8'h14;
  localparam int CTRL_SEL_BIT = 0;
  localparam int CTRL_CFG_LSB = 1;
  localparam int CTRL_CFG_MSB = 11;
  localparam int SV_W         = 14;
  localparam logic [SV_W-1:0] SV_MAX = 14'h270F;  // 9999 counts.
  localparam logic [SV_W-1:0] SV_ONE = 14'h0001;
  localparam logic [SV_W-1:0] SV_RST = 14'h0000;

  // ----------------------------------------------------------------------
  // Time range units, in milliseconds per count.
  // ----------------------------------------------------------------------
  localparam int UL_W = 22;
  localparam logic [2:0] U_1MS   = 3'h0;
  localparam logic [2:0] U_10MS  = 3'h1;
  localparam logic [2:0] U_100MS = 3'h2;
  localparam logic [2:0] U_1S    = 3'h3;
  localparam logic [2:0] U_1MIN  = 3'h4;
  localparam logic [2:0] U_1H    = 3'h5;
  localparam logic [UL_W-1:0] UL_1MS   = 22'h000001;
  localparam logic [UL_W-1:0] UL_10MS  = 22'h00000A;
  localparam logic [UL_W-1:0] UL_100MS = 22'h000064;
  localparam logic [UL_W-1:0] UL_1S    = 22'h0003E8;
  localparam logic [UL_W-1:0] UL_1MIN  = 22'h00EA60;
  localparam logic [UL_W-1:0] UL_1H    = 22'h36EE80;

  // Run configuration, held in CTRL[11:1].
  typedef struct packed {
    logic [2:0] on_unit;
    logic [2:0] off_unit;
    logic       retain;
    logic       instant;
    logic       short_width;
    logic       on_first;
    logic       count_down;
  } tft_cfg_s;

  localparam tft_cfg_s CFG_RST = '0;

  typedef enum logic {TM_IDLE, TM_RUN} tft_state_e;

endpackage

// ---- test/tft_panel_model.sv ----
`timescale 1ns/100ps

// ----------------------------------------------------------------------
// Start and reset contacts with the relay on the control output.
// ----------------------------------------------------------------------
module tft_panel_model #(
  parameter int MS_CYCLES = 20
) (
  // Clock.
  input  wire logic hclk,
  // Requests from the bench.
  input  wire logic start_req,
  input  wire logic reset_req,
  input  wire logic bounce_en,
  // Panel pins.
  output logic      start_in,
  output logic      reset_in,
  input  wire logic ctrl_out,
  // Cycles the relay stayed in the state it just left.
  output int        dwell
);
  localparam int RST_MIN = 100 * MS_CYCLES;  // Reset contact closed at least 0.1 s.

  int   bnc_left = 0;
  int   rst_left = 0;
  int   run      = 0;
  logic last_req = 1'b0;
  logic last_out = 1'b0;

  // Pins start open.
  initial begin
    start_in = 1'b0;
    reset_in = 1'b0;
    dwell    = 0;
  end

  // A closing contact chatters for a few cycles, far below either filter width.
  always @(posedge hclk) begin
    last_req <= start_req;
    if (start_req != last_req && bounce_en) begin
      bnc_left <= 6;
    end else if (bnc_left > 0) begin
      bnc_left <= bnc_left - 1;
    end
    start_in <= (bnc_left > 1) ? ~start_in : start_req;
  end

  // Once pressed, the reset contact stays closed long enough to be seen.
  always @(posedge hclk) begin
    if (reset_req) begin
      rst_left <= RST_MIN;
    end else if (rst_left > 0) begin
      rst_left <= rst_left - 1;
    end
    reset_in <= reset_req || rst_left > 1;
  end

  // The relay measures how long each state of the output lasted.
  always @(posedge hclk) begin
    last_out <= ctrl_out;
    if (ctrl_out !== last_out) begin
      dwell <= run;
      run   <= 1;
    end else begin
      run <= run + 1;
    end
  end
endmodule  // tft_panel_model

// ---- test/testbench.sv ----
`timescale 1ns/100ps

// ----------------------------------------------------------------------
// Bench for the twin flicker timer.
// ----------------------------------------------------------------------
module testbench;
  localparam int MS   = 20;        // Shortened millisecond tick.
  localparam int P100 = 100 * MS;  // Cycles in one 100 ms count.

  logic        hclk = 1'b0;
  logic        hresetn, hsel, hwrite, start_req, reset_req, bounce_en, power_ok_in;
  logic        start_in, reset_in, ctrl_out, out0, hresp;
  wire         hready;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, d, pv0;
  logic [13:0] soff, son;
  int          dwell, n_mismatch, checks_done;
  logic [7:0]  regs [5] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h20};

  tft_twin_timer #(.MS_CYCLES(MS)) i_tft_twin_timer (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .start_in(start_in),
    .reset_in(reset_in), .power_ok_in(power_ok_in), .ctrl_out(ctrl_out)
  );

  tft_panel_model #(.MS_CYCLES(MS)) i_tft_panel_model (
    .hclk(hclk), .start_req(start_req), .reset_req(reset_req), .bounce_en(bounce_en),
    .start_in(start_in), .reset_in(reset_in), .ctrl_out(ctrl_out), .dwell(dwell)
  );

  // Clock of 50 ns.
  always #25 hclk = ~hclk;

  // ----------------------------------------------------------------------
  // Shared tasks and expectations.
  // ----------------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One single AHB transfer; read data lands in d.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= w;
    hsize  <= 3'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    d = hrdata;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string n);
    bus(1'b0, a, 32'h00000000);
    check(n, d, e);
    check("hresp", {31'h00000000, hresp}, 32'h00000000);
  endtask

  // Polls the running flag until it reaches v or the poll budget ends.
  task automatic wait_st(input logic v, input int lim);
    int i;
    bus(1'b0, tft_pkg::ADDR_STATUS, 32'h00000000);
    for (i = 0; i < lim && d[3] !== v; i++) bus(1'b0, tft_pkg::ADDR_STATUS, 32'h00000000);
    check("running", d[3], v);
  endtask

  task automatic wait_out(input logic v, input int lim);
    int i;
    for (i = 0; i < lim && ctrl_out !== v; i++) @(negedge hclk);
    check("ctrl_out", ctrl_out, v);
  endtask

  // Stages a configuration in selection mode, then returns to run mode.
  task automatic apply(input tft_pkg::tft_cfg_s c);
    bus(1'b1, tft_pkg::ADDR_CTRL, {20'h00000, c, 1'b1});
    rd_chk(tft_pkg::ADDR_CTRL, {20'h00000, c, 1'b1}, "staged cfg");
    bus(1'b1, tft_pkg::ADDR_CTRL, {20'h00000, c, 1'b0});
  endtask

  task automatic pulse(input int n);
    start_req <= 1'b1;
    repeat (n) @(posedge hclk);
    start_req <= 1'b0;
  endtask

  task automatic done(input string n);
    $display("test %s finished", n);
  endtask

  function automatic tft_pkg::tft_cfg_s mk(input logic dn, input logic onf, input logic sw,
                                           input logic inst, input logic rt);
    return '{tft_pkg::U_100MS, tft_pkg::U_100MS, rt, inst, sw, onf, dn};
  endfunction

  function automatic logic [31:0] clamp(input logic [31:0] v);
    return (v > 32'(tft_pkg::SV_MAX)) ? 32'(tft_pkg::SV_MAX) : v;
  endfunction

  function automatic logic near(input int seen, input int exp);
    return (seen >= exp - MS - 3) && (seen <= exp + MS + 3);
  endfunction

  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Watchdog against a hung wait.
  initial begin
    repeat (100000) @(posedge hclk);
    n_mismatch++;
    close_out();
  end

  // ----------------------------------------------------------------------
  // Test sequence.
  // ----------------------------------------------------------------------
  initial begin
    hresetn <= 1'b0; hsel <= 1'b0; haddr <= '0; htrans <= 2'h0; hwrite <= 1'b0;
    hsize <= 3'h2; hwdata <= '0; start_req <= 1'b0; reset_req <= 1'b0;
    bounce_en <= 1'b0; power_ok_in <= 1'b1;
    n_mismatch = 0;
    checks_done = 0;
    void'($urandom(32'h2d32));
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    // Reset values, clamping and the unmapped hole.
    foreach (regs[i]) rd_chk(regs[i], 32'h00000000, "reset value");
    bus(1'b1, tft_pkg::ADDR_SET_OFF, 32'h0000FFFF);
    rd_chk(tft_pkg::ADDR_SET_OFF, clamp(32'h0000FFFF), "off clamp");
    bus(1'b1, tft_pkg::ADDR_SET_OFF, 32'h00000000);
    rd_chk(tft_pkg::ADDR_SET_OFF, 32'h00000000, "off zero");
    bus(1'b1, 8'h20, $urandom);
    rd_chk(8'h20, 32'h00000000, "hole");
    done("registers");
    // Off-first flicker started by a bouncing contact.
    soff = 14'($urandom_range(2, 1));
    son = 14'($urandom_range(2, 1));
    bus(1'b1, tft_pkg::ADDR_SET_OFF, {18'h00000, soff});
    bus(1'b1, tft_pkg::ADDR_SET_ON, {18'h00000, son});
    apply(mk(1'b0, 1'b0, 1'b0, 1'b0, 1'b0));
    bounce_en <= 1'b1;
    start_req <= 1'b1;
    wait_st(1'b1, 400);
    check("out first", ctrl_out, 1'b0);
    rd_chk(tft_pkg::ADDR_PV, 32'h00000000, "pv up");
    rd_chk(tft_pkg::ADDR_DISP, {18'h00000, soff}, "disp off");
    start_req <= 1'b0;
    wait_out(1'b1, 3 * P100);
    rd_chk(tft_pkg::ADDR_DISP, {18'h00000, son}, "disp on");
    wait_out(1'b0, 3 * P100);
    @(negedge hclk);
    check("on dwell", near(dwell, son * P100), 1'b1);
    wait_out(1'b1, 3 * P100);
    @(negedge hclk);
    check("off dwell", near(dwell, soff * P100), 1'b1);
    wait_st(1'b1, 1);
    done("off first");
    // Reset input clears, then a held start restarts on release.
    bounce_en <= 1'b0;
    start_req <= 1'b1;
    reset_req <= 1'b1;
    @(posedge hclk);
    reset_req <= 1'b0;
    wait_st(1'b0, 400);
    repeat (200) @(posedge hclk);
    check("out in reset", ctrl_out, 1'b0);
    rd_chk(tft_pkg::ADDR_PV, 32'h00000000, "pv in reset");
    wait_st(1'b1, 1000);
    check("out restart", ctrl_out, 1'b0);
    done("reset");
    // Selection mode suspends; a new configuration restarts instantly.
    start_req <= 1'b0;
    wait_out(1'b1, 3 * P100);
    bus(1'b1, tft_pkg::ADDR_CTRL, {20'h00000, mk(1'b0, 1'b0, 1'b0, 1'b0, 1'b0), 1'b1});
    wait_out(1'b0, 4);
    repeat (500) @(posedge hclk);
    rd_chk(tft_pkg::ADDR_PV, 32'h00000000, "pv select");
    wait_st(1'b0, 1);
    son = 14'($urandom_range(2, 1));
    bus(1'b1, tft_pkg::ADDR_SET_ON, {18'h00000, son});
    apply(mk(1'b1, 1'b1, 1'b1, 1'b1, 1'b0));
    wait_st(1'b1, 100);
    check("out on first", ctrl_out, 1'b1);
    rd_chk(tft_pkg::ADDR_DISP, {18'h00000, son}, "disp on first");
    rd_chk(tft_pkg::ADDR_PV, {18'h00000, son}, "pv down");
    wait_out(1'b0, 3 * P100);
    done("selection");
    // Pulses shorter and longer than the filter width.
    apply(mk(1'b0, 1'b0, 1'b0, 1'b0, 1'b0));
    pulse(10 * MS);
    repeat (30 * MS) @(posedge hclk);
    wait_st(1'b0, 1);
    apply(mk(1'b0, 1'b0, 1'b1, 1'b0, 1'b0));
    pulse(10 * MS);
    wait_st(1'b1, 100);
    done("debounce");
    // Power loss freezes the retaining variant and clears the other.
    apply(mk(1'b0, 1'b0, 1'b1, 1'b0, 1'b1));
    pulse(5 * MS);
    wait_st(1'b1, 100);
    repeat (P100 + P100 / 2) @(posedge hclk);
    power_ok_in <= 1'b0;
    repeat (10) @(posedge hclk);
    bus(1'b0, tft_pkg::ADDR_PV, 32'h00000000);
    pv0 = d;
    out0 = ctrl_out;
    repeat (P100) @(posedge hclk);
    rd_chk(tft_pkg::ADDR_PV, pv0, "pv frozen");
    check("out frozen", ctrl_out, out0);
    power_ok_in <= 1'b1;
    wait_st(1'b1, 10);
    apply(mk(1'b1, 1'b0, 1'b1, 1'b0, 1'b0));
    start_req <= 1'b1;
    wait_st(1'b1, 100);
    power_ok_in <= 1'b0;
    repeat (10) @(posedge hclk);
    check("out power low", ctrl_out, 1'b0);
    rd_chk(tft_pkg::ADDR_PV, {18'h00000, soff}, "pv power low");
    power_ok_in <= 1'b1;
    wait_st(1'b1, 100);
    done("power");
    // Millisecond and 10 ms ranges, on-first, each period 100 ms.
    bus(1'b1, tft_pkg::ADDR_SET_OFF, 32'h00000064);
    bus(1'b1, tft_pkg::ADDR_SET_ON, 32'h0000000A);
    apply('{tft_pkg::U_10MS, tft_pkg::U_1MS, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0});
    wait_out(1'b1, 10);
    wait_out(1'b0, 3 * P100);
    wait_out(1'b1, 3 * P100);
    @(negedge hclk);
    check("ms off dwell", near(dwell, P100), 1'b1);
    wait_out(1'b0, 3 * P100);
    @(negedge hclk);
    check("10 ms on dwell", near(dwell, P100), 1'b1);
    done("ranges");
    close_out();
  end
endmodule  // testbench
